//--- src/bmled_pkg.sv
// bmled_pkg: constants, enums and carrier structs for the bus master status indicator driver.
// assumes a 40 MHz system clock; timing counts are derived here from printed times.
package bmled_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned BMLED_CLK_HZ = 40000000;
    localparam int unsigned BMLED_FLASH_HALF_MS = 100;
    localparam int unsigned BMLED_FLASH_HALF_CYC = (BMLED_CLK_HZ / 1000) * BMLED_FLASH_HALF_MS;
    // acyclic pattern steps on a shorter tick so random run lengths vary
    localparam int unsigned BMLED_RAND_TICK_MS = 50;
    localparam int unsigned BMLED_RAND_TICK_CYC = (BMLED_CLK_HZ / 1000) * BMLED_RAND_TICK_MS;
    localparam int unsigned BMLED_CNT_W = 24;

    // ----------------------------------------------------------------
    // pseudo-random generator
    // ----------------------------------------------------------------
    localparam int unsigned BMLED_LFSR_W = 8;
    localparam logic [7:0] BMLED_LFSR_SEED = 8'h5a;
    localparam logic [7:0] BMLED_LFSR_TAPS = 8'hb8;
    localparam int unsigned BMLED_RUN_W = 3;

    // ----------------------------------------------------------------
    // display selection
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        BMLED_SHOW_OFF = 3'b000,
        BMLED_SHOW_GRN_ON = 3'b001,
        BMLED_SHOW_GRN_FLASH = 3'b010,
        BMLED_SHOW_GRN_RAND = 3'b011,
        BMLED_SHOW_RED_FLASH = 3'b100,
        BMLED_SHOW_RED_ON = 3'b101
    } bmled_show_e;

    typedef struct packed {
        logic stack_valid;
        logic power_good;
        logic all_slaves_ok;
        logic configured;
        logic bus_released;
        logic config_bad;
        logic some_slave_lost;
        logic all_slaves_lost;
        logic serious_error;
        logic redundant_mode;
        logic active_master_missing;
    } bmled_status_s;

    typedef struct packed {
        logic duo_green;
        logic duo_red;
        logic station_green_indicator;
        logic fault_red;
    } bmled_leds_s;

    localparam bmled_leds_s BMLED_LEDS_OFF = '{default: 1'b0};

endpackage : bmled_pkg

//--- src/bmled_pattern.sv
// bmled_pattern: flash-timing prescalers and pseudo-random acyclic flasher.
// assumes clk at the package rate; reset asynchronous, active high.
`timescale 1ns/1ps
module bmled_pattern
#(
    parameter int unsigned HALF_CYC = bmled_pkg::BMLED_FLASH_HALF_CYC,
    parameter int unsigned RAND_CYC = bmled_pkg::BMLED_RAND_TICK_CYC
)
(
    input wire logic clk,
    input wire logic reset,
    output logic flash_5hz,
    output logic flash_rand
);
    import bmled_pkg::*;

    logic [BMLED_CNT_W-1:0] half_cnt;
    logic [BMLED_CNT_W-1:0] next_half_cnt;
    logic next_flash_5hz;
    logic [BMLED_CNT_W-1:0] rand_cnt;
    logic [BMLED_CNT_W-1:0] next_rand_cnt;
    logic [BMLED_LFSR_W-1:0] lfsr;
    logic [BMLED_LFSR_W-1:0] next_lfsr;
    logic [BMLED_RUN_W-1:0] run;
    logic [BMLED_RUN_W-1:0] next_run;
    logic next_flash_rand;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_half_cnt = half_cnt + 1'b1;
        next_flash_5hz = flash_5hz;
        if (half_cnt == BMLED_CNT_W'(HALF_CYC - 1))
        begin
            next_half_cnt = '0;
            next_flash_5hz = ~flash_5hz; // 100 ms on, 100 ms off
        end
        next_rand_cnt = rand_cnt + 1'b1;
        next_lfsr = lfsr;
        next_run = run;
        next_flash_rand = flash_rand;
        if (rand_cnt == BMLED_CNT_W'(RAND_CYC - 1))
        begin
            next_rand_cnt = '0;
            next_lfsr = {lfsr[BMLED_LFSR_W-2:0], ^(lfsr & BMLED_LFSR_TAPS)};
            if (run == '0)
            begin
                // random run length 1..8 ticks breaks any fixed period
                next_flash_rand = ~flash_rand;
                next_run = lfsr[BMLED_RUN_W-1:0];
            end
            else
            begin
                next_run = run - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            half_cnt <= '0;
            flash_5hz <= 1'b1;
            rand_cnt <= '0;
            lfsr <= BMLED_LFSR_SEED;
            run <= '0;
            flash_rand <= 1'b0;
        end
        else
        begin
            half_cnt <= next_half_cnt;
            flash_5hz <= next_flash_5hz;
            rand_cnt <= next_rand_cnt;
            lfsr <= next_lfsr;
            run <= next_run;
            flash_rand <= next_flash_rand;
        end
    end

endmodule : bmled_pattern

//--- src/bmled_top.sv
// bmled_top: status indicator driver for a fieldbus master, duo-LED or two-LED scheme.
// assumes status bits come from firmware on another clock and pass the pin synchroniser.
// Behaviour
// - duo variant lights green steadily when all slaves communicate.
// - green flashes 5 Hz when configured but communication not released.
// - green flashes acyclic when configuration missing or faulty.
// - red flashes 5 Hz when some, not all, slaves are lost.
// - red steady when all slaves lost or serious error reported.
// - redundant mode, active master missing, red steady.
// - no power or network power absent, everything dark.
// - 5 Hz pattern is 100 ms on, 100 ms off, repeating.
// - acyclic pattern toggles at irregular intervals.
// - duo scheme on current hardware, two-LED scheme otherwise.
// - two-LED variant, green dark while red flashes or glows.
// - two-LED variant, red dark when no error exists.
// - two-LED variant, both dark means power missing; code also leaves both dark if all_slaves_ok is low and no other case applies.
`timescale 1ns/1ps
module bmled_top
#(
    parameter int unsigned HALF_CYC = bmled_pkg::BMLED_FLASH_HALF_CYC,
    parameter int unsigned RAND_CYC = bmled_pkg::BMLED_RAND_TICK_CYC
)
(
    input wire logic clk,
    input wire logic reset,
    input wire bmled_pkg::bmled_status_s status,
    input wire logic two_led_scheme,
    output bmled_pkg::bmled_leds_s leds,
    output bmled_pkg::bmled_show_e show
);
    import bmled_pkg::*;

    localparam int unsigned ST_W = $bits(bmled_status_s);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // three stages; a level change counts once stages two and three agree
    logic [ST_W:0] sync1;
    logic [ST_W:0] sync2;
    logic [ST_W:0] sync3;
    logic [ST_W:0] held;
    logic [ST_W:0] next_held;

    always_comb
    begin
        next_held = held;
        for (int i = 0; i <= ST_W; i++)
        begin
            if (sync2[i] == sync3[i])
            begin
                next_held[i] = sync3[i];
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            held <= '0;
        end
        else
        begin
            sync1 <= {two_led_scheme, status};
            sync2 <= sync1;
            sync3 <= sync2;
            held <= next_held;
        end
    end

    bmled_status_s st;
    logic two_led;

    assign st = bmled_status_s'(held[ST_W-1:0]);
    assign two_led = held[ST_W];

    // ----------------------------------------------------------------
    // pattern sources
    // ----------------------------------------------------------------
    logic flash_5hz;
    logic flash_rand;

    bmled_pattern #(
        .HALF_CYC(HALF_CYC),
        .RAND_CYC(RAND_CYC)
    ) u_pattern (
        .clk(clk),
        .reset(reset),
        .flash_5hz(flash_5hz),
        .flash_rand(flash_rand)
    );

    // ----------------------------------------------------------------
    // status priority
    // ----------------------------------------------------------------
    bmled_show_e next_show;

    always_comb
    begin
        next_show = BMLED_SHOW_OFF;
        if (!st.stack_valid || !st.power_good)
        begin
            next_show = BMLED_SHOW_OFF;
        end
        else if (st.all_slaves_lost || st.serious_error)
        begin
            next_show = BMLED_SHOW_RED_ON;
        end
        else if (st.redundant_mode && st.active_master_missing)
        begin
            next_show = BMLED_SHOW_RED_ON;
        end
        else if (st.some_slave_lost)
        begin
            next_show = BMLED_SHOW_RED_FLASH;
        end
        else if (!st.configured || st.config_bad)
        begin
            next_show = BMLED_SHOW_GRN_RAND;
        end
        else if (!st.bus_released)
        begin
            next_show = BMLED_SHOW_GRN_FLASH;
        end
        else if (st.all_slaves_ok)
        begin
            next_show = BMLED_SHOW_GRN_ON;
        end
    end

    // ----------------------------------------------------------------
    // drive mapping
    // ----------------------------------------------------------------
    logic grn;
    logic red;
    bmled_leds_s next_leds;

    always_comb
    begin
        grn = 1'b0;
        red = 1'b0;
        unique case (next_show)
            BMLED_SHOW_OFF: ;
            BMLED_SHOW_GRN_ON: grn = 1'b1;
            BMLED_SHOW_GRN_FLASH: grn = flash_5hz;
            BMLED_SHOW_GRN_RAND: grn = flash_rand;
            BMLED_SHOW_RED_FLASH: red = flash_5hz;
            BMLED_SHOW_RED_ON: red = 1'b1;
            default: ;
        endcase
        next_leds = BMLED_LEDS_OFF;
        if (two_led)
        begin
            // green carries no error; red dark without error
            next_leds.station_green_indicator = grn;
            next_leds.fault_red = red;
        end
        else
        begin
            // a duo LED never shows both halves at once
            next_leds.duo_green = grn;
            next_leds.duo_red = red;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            leds <= BMLED_LEDS_OFF;
            show <= BMLED_SHOW_OFF;
        end
        else
        begin
            leds <= next_leds;
            show <= next_show;
        end
    end

endmodule : bmled_top

//--- sim/bmled_top_properties.sv
// port checks for the status indicator driver
// assumes inputs reach the indicators 5 edges after they change
`timescale 1ns/1ps
module bmled_top_properties
#(
    parameter int unsigned HALF_CYC = 8,
    parameter int unsigned RAND_CYC = 4
)
(
    input wire logic clk,
    input wire logic reset,
    input wire bmled_pkg::bmled_status_s status,
    input wire logic two_led_scheme,
    input wire bmled_pkg::bmled_leds_s leds,
    input wire bmled_pkg::bmled_show_e show
);
    import bmled_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ----
    // properties
    // ----
    property p_dark;
        (!(status.stack_valid && status.power_good))[*6] |-> leds == 4'h0;
    endproperty
    a_dark: assert property (p_dark) else $error("lamp lit without power");
    property p_two;
        two_led_scheme[*6] |-> !leds.duo_green && !leds.duo_red;
    endproperty
    a_two: assert property (p_two) else $error("duo lamp used in two-lamp scheme");
    property p_duo;
        (!two_led_scheme)[*6] |-> !leds.station_green_indicator && !leds.fault_red;
    endproperty
    a_duo: assert property (p_duo) else $error("two-lamp pins used in duo scheme");
    property p_excl;
        !(leds.station_green_indicator && leds.fault_red) && !(leds.duo_green && leds.duo_red);
    endproperty
    a_excl: assert property (p_excl) else $error("green and red lit together");
    property p_grn;
        (status == 11'h7c0)[*6] |-> show == BMLED_SHOW_GRN_ON;
    endproperty
    a_grn: assert property (p_grn) else $error("green not steady with all slaves up");
    property p_lost;
        (status.all_slaves_lost && status.power_good && status.stack_valid)[*6] |-> show == BMLED_SHOW_RED_ON;
    endproperty
    a_lost: assert property (p_lost) else $error("red not steady on total loss");
    // both two-lamp pins dark once network power has been gone long enough to pass the synchroniser
    property p_quiet;
        (two_led_scheme && !status.power_good)[*6] |-> !leds.station_green_indicator && !leds.fault_red;
    endproperty
    a_quiet: assert property (p_quiet) else $error("two-lamp pin lit without power");
    // no loss, no serious fault and no missing redundant master reported: red stays dark in either scheme
    property p_redlit;
        (!status.some_slave_lost && !status.all_slaves_lost && !status.serious_error
            && !(status.redundant_mode && status.active_master_missing))[*6] |-> !leds.fault_red && !leds.duo_red;
    endproperty
    a_redlit: assert property (p_redlit) else $error("red lit without any error");
endmodule : bmled_top_properties

bind bmled_top bmled_top_properties #(.HALF_CYC(HALF_CYC), .RAND_CYC(RAND_CYC)) bmled_top_properties_inst (
    .clk(clk), .reset(reset), .status(status), .two_led_scheme(two_led_scheme), .leds(leds), .show(show));

//--- sim/bmled_viewer.sv
// operator's eye on one lamp: shortest and longest steady run
// assumes clr high between looks; runs in clk cycles
`timescale 1ns/1ps
module bmled_viewer
(
    input wire logic clk,
    input wire logic lamp,
    input wire logic clr,
    output logic [15:0] run_min,
    output logic [15:0] run_max
);
    logic last;
    logic seen;
    logic [15:0] run;
    always @(posedge clk)
    begin
        last <= lamp;
        if (clr)
        begin
            seen <= 1'b0;
            run <= 16'h0;
            run_min <= 16'hffff;
            run_max <= 16'h0;
        end
        else if (lamp != last)
        begin
            // first run after clr is partial, so dropped
            seen <= 1'b1;
            run <= 16'h1;
            if (seen && run < run_min)
                run_min <= run;
            if (seen && run > run_max)
                run_max <= run;
        end
        else
            run <= run + 16'h1;
    end
endmodule : bmled_viewer

//--- sim/testbench.sv
// self-checking bench for the status indicator driver
// assumes short flash counts: HALF_CYC 8, RAND_CYC 4
`timescale 1ns/1ps
module testbench;
    import bmled_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    bmled_status_s status = 11'h0;
    logic two_led_scheme = 1'b0;
    bmled_leds_s leds;
    bmled_show_e show;
    logic clr = 1'b1;
    logic [15:0] run_min;
    logic [15:0] run_max;
    int mismatches = 0;
    int n_checks = 0;
    logic [13:0] tab [13] = '{
        {11'h7c0, 3'h1},
        {11'h780, 3'h2},
        {11'h740, 3'h3},
        {11'h7e0, 3'h3},
        {11'h6d0, 3'h4},
        {11'h6c8, 3'h5},
        {11'h7c4, 3'h5},
        {11'h7c3, 3'h5},
        {11'h7c2, 3'h1},
        {11'h5c0, 3'h0},
        {11'h3c0, 3'h0},
        {11'h6d8, 3'h5},
        {11'h650, 3'h4}};
    bmled_top #(.HALF_CYC(8), .RAND_CYC(4)) bmled_top_inst (.clk(clk), .reset(reset), .status(status),
        .two_led_scheme(two_led_scheme), .leds(leds), .show(show));
    bmled_viewer bmled_viewer_inst (.clk(clk), .lamp(leds.duo_green), .clr(clr), .run_min(run_min),
        .run_max(run_max));
    initial forever #12.5 clk = ~clk;
    // ----
    // tasks
    // ----
    task check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task apply(input logic [10:0] st, input logic sch);
        @(negedge clk);
        status = st;
        two_led_scheme = sch;
        repeat (7) @(negedge clk);
    endtask : apply
    task look(input logic [10:0] st, input int n);
        apply(st, 1'b0);
        clr = 1'b0;
        repeat (n) @(negedge clk);
        clr = 1'b1;
    endtask : look
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    function automatic logic [3:0] want_leds(input logic [2:0] s, input logic sch);
        logic g;
        logic r;
        g = s == 3'h1;
        r = s == 3'h5;
        want_leds = sch ? {2'b00, g, r} : {g, r, 2'b00};
    endfunction : want_leds
    // ----
    // tests
    // ----
    initial
    begin
        repeat (2) @(negedge clk);
        reset = 1'b0;
        check(16'(leds), 16'h0);
        for (int s = 0; s < 2; s++)
            for (int i = 0; i < 13; i++)
            begin
                apply(tab[i][13:3], s[0]);
                check(16'(show), 16'(tab[i][2:0]));
                if (tab[i][2:0] inside {3'h0, 3'h1, 3'h5})
                    check(16'(leds), 16'(want_leds(tab[i][2:0], s[0])));
            end
        $display("test display table done");
        look(11'h780, 200);
        check(run_min, 16'h8);
        check(run_max, 16'h8);
        $display("test cyclic flash done");
        look(11'h740, 800);
        check(16'(run_min != run_max), 16'h1);
        check(16'(run_min >= 16'h4), 16'h1);
        check(16'(run_max <= 16'h20), 16'h1);
        $display("test acyclic flash done");
        reset = 1'b1;
        status = 11'h780;
        #1;
        check(16'(leds), 16'h0);
        @(negedge clk);
        reset = 1'b0;
        // flash phase restarts "on": green lit after edges 5..8, dark after edges 9..16
        repeat (6) @(negedge clk);
        check(16'(leds.duo_green), 16'h1);
        repeat (4) @(negedge clk);
        check(16'(leds.duo_green), 16'h0);
        $display("test mid-run reset done");
        give_verdict();
    end
    initial
    begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule : testbench
